// ---- swm_regs.vh ----
// timing, command and line constants for the single-wire bus master
`ifndef SWM_REGS_VH
`define SWM_REGS_VH

`define SWM_CLK_MHZ          50
// times in microseconds
`define SWM_RESET_LOW_US     500
`define SWM_RESET_MAX_US     960
`define SWM_PRES_SAMPLE_US   70
`define SWM_RESET_REC_US     410
`define SWM_SLOT_US          65
`define SWM_W0_LOW_US        60
`define SWM_W1_LOW_US        6
`define SWM_RD_LOW_US        6
`define SWM_RD_SAMPLE_US     14
`define SWM_RECOVER_US       5
// strong pull-up times
`define SWM_COPY_SPU_MS      10
`define SWM_CONV_SPU_MS      500
// cycle counts derived from the clock rate
`define SWM_RESET_LOW_CYC    (`SWM_RESET_LOW_US * `SWM_CLK_MHZ)
`define SWM_PRES_SAMPLE_CYC  (`SWM_PRES_SAMPLE_US * `SWM_CLK_MHZ)
`define SWM_RESET_REC_CYC    (`SWM_RESET_REC_US * `SWM_CLK_MHZ)
`define SWM_SLOT_CYC         (`SWM_SLOT_US * `SWM_CLK_MHZ)
`define SWM_W0_LOW_CYC       (`SWM_W0_LOW_US * `SWM_CLK_MHZ)
`define SWM_W1_LOW_CYC       (`SWM_W1_LOW_US * `SWM_CLK_MHZ)
`define SWM_RD_LOW_CYC       (`SWM_RD_LOW_US * `SWM_CLK_MHZ)
`define SWM_RD_SAMPLE_CYC    (`SWM_RD_SAMPLE_US * `SWM_CLK_MHZ)
`define SWM_RECOVER_CYC      (`SWM_RECOVER_US * `SWM_CLK_MHZ)
`define SWM_COPY_SPU_CYC     (`SWM_COPY_SPU_MS * 1000 * `SWM_CLK_MHZ)
`define SWM_CONV_SPU_CYC     (`SWM_CONV_SPU_MS * 1000 * `SWM_CLK_MHZ)
// command codes
`define SWM_CMD_WRITE_PAD    8'h4E
`define SWM_CMD_READ_PAD     8'hBE
`define SWM_CMD_COPY_PAD     8'h48
`define SWM_CMD_CONVERT      8'h44
`define SWM_CMD_RECALL       8'hB8
// operation codes on the user port
`define SWM_OP_RESET         3'h0
`define SWM_OP_WRITE         3'h1
`define SWM_OP_READ          3'h2
`define SWM_OP_SPU_COPY      3'h3
`define SWM_OP_SPU_CONV      3'h4
`define SWM_FIFO_DEPTH       16
`define SWM_FIFO_AW          4

`endif

// ---- swm_master.v ----
// single-wire bus master: reset/presence, byte slots, strong pull-up, read fifo
`timescale 1ns/1ps
`include "swm_regs.vh"

// Functional notes
// - master may reset mid write; the two trigger bytes are then undefined.
// - master may end a read early with a reset.
// - after copy, master drives strong pull-up for 10 ms, bus idle.
// - after convert, master drives strong pull-up 0.5 s, bus idle.
// - master holds line low at least 480 us, then releases.
// - every slot begins with the master pulling the line low.
// - after strong pull-up ends, master releases line to resistor idle.
// - reset low time plus rise stays below 960 us.
// - commands only after reset, presence and rom selection; the master does not enforce this and takes a write op whenever idle with room in the read fifo.

// ----------------------------------------------------------------------------
// read-data fifo
// ----------------------------------------------------------------------------
module swm_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_reg;
   reg [AW-1:0]    rd_reg;
   reg [AW:0]      cnt_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data  = mem[rd_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clock) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_reg  <= {AW{1'b0}};
         rd_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
         if (push & ~pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop & ~push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule // swm_fifo

// ----------------------------------------------------------------------------
// bus master
// ----------------------------------------------------------------------------
module swm_master #(
   parameter COPY_SPU_CYC = `SWM_COPY_SPU_CYC,
   parameter CONV_SPU_CYC = `SWM_CONV_SPU_CYC
) (
   input  wire       clock,
   input  wire       rst,
   input  wire       op_valid,
   output wire       op_ready,
   input  wire [2:0] op_code,
   input  wire [7:0] op_data,
   output wire       rd_valid,
   input  wire       rd_ready,
   output wire [7:0] rd_data,
   output wire       busy,
   output wire       presence,
   output wire       spu_active,
   input  wire       line_in,
   output wire       line_out,
   output wire       line_oe_n,
   output wire       spu_en
);
   localparam S_IDLE  = 6'h01;
   localparam S_RLOW  = 6'h02;
   localparam S_RWAIT = 6'h04;
   localparam S_SLOT  = 6'h08;
   localparam S_SPU   = 6'h10;
   localparam S_PUSH  = 6'h20;

   // last cycle of each phase, at counter width so every compare is width-matched
   localparam [24:0] RLOW_LAST = `SWM_RESET_LOW_CYC - 1;
   localparam [24:0] PRES_LAST = `SWM_PRES_SAMPLE_CYC - 1;
   localparam [24:0] RREC_LAST = `SWM_RESET_REC_CYC - 1;
   localparam [24:0] RDLO_LAST = `SWM_RD_LOW_CYC - 1;
   localparam [24:0] RDSM_LAST = `SWM_RD_SAMPLE_CYC - 1;
   localparam [24:0] W1LO_LAST = `SWM_W1_LOW_CYC - 1;
   localparam [24:0] W0LO_LAST = `SWM_W0_LOW_CYC - 1;
   localparam [24:0] SLOT_LAST = `SWM_SLOT_CYC + `SWM_RECOVER_CYC - 1;

   reg [5:0]  state_reg;
   reg [5:0]  state_next;
   reg [24:0] cnt_reg;
   reg [24:0] cnt_next;
   reg [24:0] spu_len_reg;
   reg [2:0]  bit_reg;
   reg [2:0]  bit_next;
   reg [7:0]  sh_reg;
   reg [7:0]  sh_next;
   reg        is_read_reg;
   reg        is_read_next;
   reg        drive_reg;
   reg        drive_next;
   reg        pres_reg;
   reg        pres_next;
   reg        spu_reg;
   reg        spu_next;
   wire       fifo_in_ready;
   wire       cur_bit;
   wire       take;

   assign op_ready   = state_reg[0] & fifo_in_ready;
   assign take       = op_valid & op_ready;
   assign busy       = ~state_reg[0];
   assign presence   = pres_reg;
   assign spu_active = spu_reg;
   assign spu_en     = spu_reg;
   assign line_out   = 1'b0;
   assign line_oe_n  = ~drive_reg;
   assign cur_bit    = sh_reg[0];

   always @* begin
      state_next   = state_reg;
      cnt_next     = cnt_reg + 25'h0000001;
      bit_next     = bit_reg;
      sh_next      = sh_reg;
      is_read_next = is_read_reg;
      drive_next   = drive_reg;
      pres_next    = pres_reg;
      spu_next     = spu_reg;
      case (state_reg)
         S_IDLE: begin
            cnt_next   = 25'h0000000;
            drive_next = 1'b0;
            spu_next   = 1'b0;
            if (take) begin
               case (op_code)
                  `SWM_OP_RESET: begin
                     // a reset op may follow a cut write or read at any byte
                     state_next = S_RLOW;
                     drive_next = 1'b1;
                     pres_next  = 1'b0;
                  end
                  `SWM_OP_WRITE, `SWM_OP_READ: begin
                     state_next   = S_SLOT;
                     drive_next   = 1'b1;
                     bit_next     = 3'h0;
                     is_read_next = (op_code == `SWM_OP_READ);
                     sh_next      = (op_code == `SWM_OP_READ) ? 8'hFF : op_data;
                  end
                  `SWM_OP_SPU_COPY, `SWM_OP_SPU_CONV: begin
                     state_next = S_SPU;
                     spu_next   = 1'b1;
                  end
                  default: begin
                     state_next = S_IDLE;
                  end
               endcase
            end
         end
         S_RLOW: begin
            // low time lies between 480 and 960 us
            if (cnt_reg == RLOW_LAST) begin
               state_next = S_RWAIT;
               drive_next = 1'b0;
               cnt_next   = 25'h0000000;
            end
         end
         S_RWAIT: begin
            // sample presence once, then let the line recover
            if (cnt_reg == PRES_LAST) begin
               pres_next = ~line_in;
            end
            if (cnt_reg == RREC_LAST) begin
               state_next = S_IDLE;
            end
         end
         S_SLOT: begin
            // read: short low then sample; write: short low for 1, long low for 0
            if (is_read_reg) begin
               if (cnt_reg == RDLO_LAST) begin
                  drive_next = 1'b0;
               end
               if (cnt_reg == RDSM_LAST) begin
                  sh_next = {line_in, sh_reg[7:1]};
               end
            end else begin
               if (cnt_reg == (cur_bit ? W1LO_LAST : W0LO_LAST)) begin
                  drive_next = 1'b0;
               end
            end
            if (cnt_reg == SLOT_LAST) begin
               cnt_next = 25'h0000000;
               if (~is_read_reg) begin
                  sh_next = {1'b0, sh_reg[7:1]};
               end
               if (bit_reg == 3'h7) begin
                  state_next = is_read_reg ? S_PUSH : S_IDLE;
               end else begin
                  bit_next   = bit_reg + 3'h1;
                  drive_next = 1'b1;
               end
            end
         end
         S_SPU: begin
            // line stays released; spu_en alone drives the strong pull-up
            if (cnt_reg == spu_len_reg - 25'h0000001) begin
               state_next = S_IDLE;
               spu_next   = 1'b0;
            end
         end
         S_PUSH: begin
            // one cycle to hand the finished byte to the fifo
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
            drive_next = 1'b0;
            spu_next   = 1'b0;
         end
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg   <= S_IDLE;
         cnt_reg     <= 25'h0000000;
         spu_len_reg <= 25'h0000001;
         bit_reg     <= 3'h0;
         sh_reg      <= 8'h00;
         is_read_reg <= 1'b0;
         drive_reg   <= 1'b0;
         pres_reg    <= 1'b0;
         spu_reg     <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         bit_reg     <= bit_next;
         sh_reg      <= sh_next;
         is_read_reg <= is_read_next;
         drive_reg   <= drive_next;
         pres_reg    <= pres_next;
         spu_reg     <= spu_next;
         if (take) begin
            spu_len_reg <= (op_code == `SWM_OP_SPU_CONV) ? CONV_SPU_CYC[24:0]
                                                          : COPY_SPU_CYC[24:0];
         end
      end
   end

   // finished read bytes are queued; the op port stalls while the queue is full
   swm_fifo #(
      .WIDTH (8),
      .DEPTH (`SWM_FIFO_DEPTH),
      .AW    (`SWM_FIFO_AW)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (state_reg == S_PUSH),
      .in_ready  (fifo_in_ready),
      .in_data   (sh_reg),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );
endmodule // swm_master

// ---- swm_master_sva.sv ----
// assertion checker for the single-wire bus master
`timescale 1ns/1ps
module swm_master_sva #(
   parameter COPY_SPU_CYC = 100,
   parameter CONV_SPU_CYC = 200
) (
   input wire       clock,
   input wire       rst,
   input wire       op_valid,
   input wire       op_ready,
   input wire [2:0] op_code,
   input wire       busy,
   input wire       presence,
   input wire       line_oe_n,
   input wire       spu_en
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------------
   // helper counters: low run of the line, length of the pull-up window
   // ------------------------------------------------------------------
   reg  [15:0] low_cnt_reg;
   reg  [31:0] spu_cnt_reg;
   reg         conv_reg;
   wire        take = op_valid && op_ready;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         low_cnt_reg <= 16'h0000;
         spu_cnt_reg <= 32'h0;
         conv_reg    <= 1'b0;
      end else begin
         low_cnt_reg <= line_oe_n ? 16'h0000 : low_cnt_reg + 16'h0001;
         spu_cnt_reg <= spu_en ? spu_cnt_reg + 32'h1 : 32'h0;
         if (take)
            conv_reg <= (op_code == 3'h4);
      end
   end
   sequence s_take_spu;
      take && (op_code == 3'h3 || op_code == 3'h4);
   endsequence
   sequence s_take_slot;
      take && (op_code == 3'h1 || op_code == 3'h2);
   endsequence
   a_spu_prompt: assert property (s_take_spu |-> ##[1:3] spu_en)
      else $error("pull-up did not follow its op");
   a_slot_start: assert property (s_take_slot |-> ##[1:4] !line_oe_n)
      else $error("slot did not start with the line low");
   a_spu_no_pull: assert property (spu_en |-> line_oe_n)
      else $error("line pulled low during pull-up");
   a_spu_release: assert property ($fell(spu_en) |-> line_oe_n [*2])
      else $error("line not left idle after pull-up");
   a_spu_length: assert property ($fell(spu_en) |->
      spu_cnt_reg >= (conv_reg ? CONV_SPU_CYC : COPY_SPU_CYC))
      else $error("pull-up window too short");
   a_reset_len: assert property ($rose(line_oe_n) |-> low_cnt_reg <= 16'h0C1C ||
      (low_cnt_reg >= 16'h5DC0 && low_cnt_reg < 16'hBB80))
      else $error("line low time outside slot or reset limits");
   a_presence_clr: assert property (take && op_code == 3'h0 |-> ##[1:2] !presence)
      else $error("presence not cleared by reset op");
   a_busy_refuse: assert property (busy |-> !op_ready)
      else $error("ready while busy");
   a_busy_take: assert property (take && op_code <= 3'h4 |=> busy)
      else $error("busy did not follow a taken op");
endmodule // swm_master_sva

bind swm_master swm_master_sva #(.COPY_SPU_CYC(COPY_SPU_CYC), .CONV_SPU_CYC(CONV_SPU_CYC))
   u_sva (.clock(clock), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
   .op_code(op_code), .busy(busy), .presence(presence), .line_oe_n(line_oe_n),
   .spu_en(spu_en));

// ---- swm_sensor_model.sv ----
// behavioural model of the sensor on the single-wire line
`timescale 1ns/1ps
module swm_sensor_model #(
   parameter [7:0] TEMP_LSB = 8'h5A
) (
   input  wire       line,
   output reg        pull_low,
   output reg  [7:0] cmd_byte
);
   reg [7:0] pad [0:7];
   reg [7:0] high_alarm_trigger, low_alarm_trigger, wr_byte;
   reg [1:0] mode;
   integer   bit_n, byte_n;
   realtime  fall_t;
   initial begin
      pull_low = 1'b0;
      cmd_byte = 8'h00;
      mode = 2'h0;
      bit_n = 0;
      byte_n = 0;
      fall_t = 0.0;
      pad[0] = TEMP_LSB;
      pad[1] = 8'h00;
      wr_byte = 8'h00;
      // nonvolatile triggers are recalled into the pad at power-up
      high_alarm_trigger = 8'h4B;
      low_alarm_trigger = 8'h46;
      pad[2] = high_alarm_trigger;
      pad[3] = low_alarm_trigger;
      pad[4] = 8'hFF;
      pad[5] = 8'hFF;
      pad[6] = 8'h0C;
      pad[7] = 8'h10;
   end
   // a long low resets the slot logic, then presence is answered
   always @(posedge line) begin
      if ($realtime - fall_t > 120000.0) begin
         mode = 2'h0;
         bit_n = 0;
         byte_n = 0;
         #30000 pull_low = 1'b1;
         #120000 fall_t = $realtime;
         pull_low = 1'b0;
      end
   end
   always @(negedge line) begin
      if (!pull_low) begin
         fall_t = $realtime;
         if (mode == 2'h1) begin
            if (!pad[byte_n][bit_n]) begin
               pull_low = 1'b1;
               #30000 pull_low = 1'b0;
            end
            bit_n = (bit_n + 1) % 8;
            if (bit_n == 0)
               byte_n = (byte_n + 1) % 8;
         end else if (mode == 2'h3) begin
            #30000 wr_byte = {line, wr_byte[7:1]};
            bit_n = bit_n + 1;
            if (bit_n == 8) begin
               pad[byte_n] = wr_byte;
               bit_n = 0;
               byte_n = byte_n + 1;
               if (byte_n == 4)
                  mode = 2'h2;
            end
         end else if (mode == 2'h0) begin
            #30000 cmd_byte = {line, cmd_byte[7:1]};
            bit_n = bit_n + 1;
            if (bit_n == 8) begin
               // data phase starts at bit 0 of its first byte
               bit_n = 0;
               byte_n = 0;
               mode = 2'h2;
               case (cmd_byte)
                  8'hBE: mode = 2'h1;
                  8'h4E: begin
                     mode = 2'h3;
                     byte_n = 2;
                  end
                  8'h48: begin
                     high_alarm_trigger = pad[2];
                     low_alarm_trigger = pad[3];
                  end
                  8'hB8: begin
                     pad[2] = high_alarm_trigger;
                     pad[3] = low_alarm_trigger;
                  end
                  default: mode = 2'h2; // conversion takes no data bytes
               endcase
            end
         end
      end
   end
endmodule // swm_sensor_model

// ---- swm_master_bench.sv ----
// self-checking bench for the single-wire bus master
`timescale 1ns/1ps
module swm_master_bench;
   reg         clock, rst, op_valid, rd_ready;
   reg  [2:0]  op_code, c;
   reg  [7:0]  op_data, d, e;
   reg  [18:0] rows [0:4];
   wire        op_ready, rd_valid, busy, presence, spu_active;
   wire        line_out, line_oe_n, spu_en, pull_low, line;
   wire [7:0]  rd_data, cmd_byte;
   integer     fails, samples_checked, i, n;
   // open-drain line with resistor pull-up
   assign line = !((!line_oe_n && !line_out) || pull_low);
   swm_master #(.COPY_SPU_CYC(100), .CONV_SPU_CYC(200)) dut (.clock(clock), .rst(rst),
      .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_data(op_data),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
      .presence(presence), .spu_active(spu_active), .line_in(line), .line_out(line_out),
      .line_oe_n(line_oe_n), .spu_en(spu_en));
   swm_sensor_model #(.TEMP_LSB(8'h5A)) u_sensor (.line(line), .pull_low(pull_low),
      .cmd_byte(cmd_byte));
   always #10 clock = ~clock;
   task check(input string name, input [7:0] exp, input [7:0] got);
   begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("Error %0s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   task tally_and_finish;
   begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   // present one op, wait until it is taken and the master is idle again
   task run_op(input [2:0] code, input [7:0] data);
   begin
      @(posedge clock);
      op_code <= code;
      op_data <= data;
      op_valid <= 1'b1;
      @(posedge clock);
      while (!op_ready) @(posedge clock);
      op_valid <= 1'b0;
      n = 0;
      repeat (2) @(negedge clock);
      while (busy && n < 60000) begin
         @(negedge clock);
         n = n + 1;
      end
      // a spent limit counts as a mismatch
      if (n >= 60000)
         fails = fails + 1;
      @(negedge clock);
   end
   endtask
   initial begin
      repeat (112000) @(posedge clock);
      fails = fails + 1;
      tally_and_finish;
   end
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      op_valid = 1'b0;
      rd_ready = 1'b0;
      op_code = 3'h0;
      op_data = 8'h00;
      fails = 0;
      samples_checked = 0;
      rows[0] = {3'h0, 8'h00, 8'h01};
      rows[1] = {3'h1, 8'hBE, 8'hBE};
      rows[2] = {3'h2, 8'h00, 8'h5A};
      rows[3] = {3'h3, 8'h00, 8'h00};
      rows[4] = {3'h4, 8'h00, 8'h00};
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
         {c, d, e} = rows[i];
         run_op(c, d);
         case (c)
            3'h0: check("presence", e, {7'h00, presence});
            3'h1: check("command", e, cmd_byte);
            3'h2: begin
               check("rd_valid", 8'h01, {7'h00, rd_valid});
               check("rd_data", e, rd_data);
               @(posedge clock) rd_ready <= 1'b1;
               @(posedge clock) rd_ready <= 1'b0;
            end
            default: check("spu_en", e, {7'h00, spu_en});
         endcase
      end
      // an unused op code is taken and leaves the master idle
      run_op(3'h7, 8'h00);
      check("busy", 8'h00, {7'h00, busy});
      check("rd_valid", 8'h00, {7'h00, rd_valid});
      // conversion window: line released, pull-up on for exactly 200 cycles
      @(posedge clock);
      op_code <= 3'h4;
      op_valid <= 1'b1;
      @(posedge clock) op_valid <= 1'b0;
      @(negedge clock);
      check("spu_active", 8'h01, {7'h00, spu_active});
      check("line_oe_n", 8'h01, {7'h00, line_oe_n});
      n = 0;
      while (spu_active && n < 1000) begin
         @(negedge clock);
         n = n + 1;
      end
      check("conv_window", 8'hC8, n[7:0]);
      check("busy", 8'h00, {7'h00, busy});
      // reset in the middle of a write slot returns the line, spu_en, presence, busy and op_ready outputs to idle
      @(posedge clock);
      op_code <= 3'h1;
      op_data <= 8'h00;
      op_valid <= 1'b1;
      @(posedge clock) op_valid <= 1'b0;
      repeat (1000) @(posedge clock);
      rst <= 1'b1;
      @(negedge clock);
      check("line_oe_n", 8'h01, {7'h00, line_oe_n});
      check("spu_en", 8'h00, {7'h00, spu_en});
      check("presence", 8'h00, {7'h00, presence});
      check("busy", 8'h00, {7'h00, busy});
      check("op_ready", 8'h01, {7'h00, op_ready});
      check("line_out", 8'h00, {7'h00, line_out});
      @(posedge clock) rst <= 1'b0;
      // after the second release a copy window runs and the line ends idle
      run_op(3'h3, 8'h00);
      check("busy", 8'h00, {7'h00, busy});
      check("spu_active", 8'h00, {7'h00, spu_active});
      check("line_oe_n", 8'h01, {7'h00, line_oe_n});
      tally_and_finish;
   end
endmodule // swm_master_bench
